// >>> logic/flash_ctrl_map.svh
// Address, field and reset constants of the flash control block
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// ****************************************
// Configuration field addresses
// ****************************************
`define FC_KEY0_ADDR      18'h3FF00
`define FC_KEY_STEP       18'h00002
`define FC_PROT_ADDR      18'h3FF0C
`define FC_LOCK_ADDR      18'h3FF0E
`define FC_PARAM_ADDR     18'h3FF10

// ****************************************
// Field layout
// ****************************************
`define FC_LOCK_LSB       0
`define FC_KEY_EN_LSB     6
`define FC_LOCK_UNSECURED 2'h2
`define FC_KEY_EN_ENABLED 2'h2
`define FC_KEY_ZERO       16'h0000
`define FC_KEY_ONES       16'hFFFF
`define FC_NUM_KEYS       4
`define FC_NUM_CCOB       6
`define FC_LAST_RD        3'h6

// ****************************************
// Command codes
// ****************************************
`define FC_OP_ERASE_VERIFY_ALL 8'h01
`define FC_OP_ERASE_ALL        8'h08
`define FC_OP_KEY_VERIFY       8'h0C

// ****************************************
// Fallback values after a failed reset load
// ****************************************
`define FC_DFLT_PARAM     16'h0000
`define FC_DFLT_PROG_PROT 8'h00
`define FC_DFLT_DATA_PROT 8'h00
`define FC_DFLT_OPTION    8'hFF
`define FC_DFLT_LOCK      8'hFF

`endif

// >>> logic/flash_ctrl_pkg.sv
// Types shared by the flash control block
package flash_ctrl_pkg;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [2:0] {
		ST_HOLD   = 3'b000,
		ST_LOAD   = 3'b001,
		ST_IDLE   = 3'b010,
		ST_ENGINE = 3'b011,
		ST_KEY    = 3'b100
	} state_e;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
		logic        single_fault;
		logic        double_fault;
	} nvm_rd_rsp_s;

	typedef struct packed {
		logic [15:0] param;
		logic [7:0]  program_array_protection;
		logic [7:0]  data_array_protection;
		logic [7:0]  option_register;
		logic [7:0]  lock_register;
	} config_s;

endpackage

// >>> logic/flash_irq_security_reset_ctrl.sv
// Flash interrupt, security and reset-sequence control
`timescale 1ns/10ps
`include "flash_ctrl_map.svh"

module flash_irq_security_reset_ctrl (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       special_single_chip_i,
	input  wire logic                       wait_mode_i,
	input  wire logic                       stop_req_i,
	input  wire logic                       command_complete_irq_enable_i,
	input  wire logic                       double_fault_irq_enable_i,
	input  wire logic                       single_fault_irq_enable_i,
	input  wire logic                       double_fault_clr_i,
	input  wire logic                       single_fault_clr_i,
	input  wire logic                       ecc_single_i,
	input  wire logic                       ecc_double_i,
	input  wire logic                       ccob_wr_i,
	input  wire logic                       ccob_sel_index_i,
	input  wire logic [15:0]                ccob_wdata_i,
	input  wire logic                       cmd_launch_i,
	input  wire logic                       engine_done_i,
	input  wire logic [1:0]                 engine_status_i,
	input  wire logic                       engine_erased_i,
	input  wire flash_ctrl_pkg::nvm_rd_rsp_s nvm_rd_rsp_i,
	output logic                            nvm_rd_req_o,
	output logic [17:0]                     nvm_rd_addr_o,
	output logic                            engine_start_o,
	output logic [7:0]                      engine_op_o,
	output logic                            cpu_stall_o,
	output logic                            read_invalid_o,
	output logic                            stop_ack_o,
	output logic                            wake_o,
	output logic                            command_complete_flag_o,
	output logic                            double_fault_flag_o,
	output logic                            single_fault_flag_o,
	output logic [1:0]                      verify_error_status_o,
	output logic                            access_error_o,
	output logic                            cmd_irq_o,
	output logic                            err_irq_o,
	output logic [1:0]                      protection_lock_state_o,
	output logic                            secured_o,
	output logic [2:0]                      command_index_register_o,
	output flash_ctrl_pkg::config_s         config_o
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic key_ok(input logic [15:0] k);
		key_ok = (k != `FC_KEY_ZERO) && (k != `FC_KEY_ONES);
	endfunction

	function automatic logic [17:0] load_addr(input logic [2:0] idx);
		case (idx)
			3'h0: load_addr = `FC_PARAM_ADDR;
			3'h1: load_addr = `FC_KEY0_ADDR;
			3'h2: load_addr = 18'(`FC_KEY0_ADDR + `FC_KEY_STEP);
			3'h3: load_addr = 18'(`FC_KEY0_ADDR + 2 * `FC_KEY_STEP);
			3'h4: load_addr = 18'(`FC_KEY0_ADDR + 3 * `FC_KEY_STEP);
			3'h5: load_addr = `FC_PROT_ADDR;
			default: load_addr = `FC_LOCK_ADDR;
		endcase
	endfunction

	// Unsecured: all. Secured: only erase verify, key verify, erase all in special
	function automatic logic cmd_allowed(input logic [7:0] op, input logic special,
			input logic secure);
		if (!secure) begin
			cmd_allowed = 1'b1;
		end else begin
			cmd_allowed = (op == `FC_OP_ERASE_VERIFY_ALL) || (op == `FC_OP_KEY_VERIFY) ||
				(special && (op == `FC_OP_ERASE_ALL));
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	flash_ctrl_pkg::state_e  state_r, state_nxt;
	logic [2:0]              rd_idx_r;
	logic                    load_err_r;
	logic [15:0]             keys_r [0:`FC_NUM_KEYS-1];
	logic [15:0]             ccob_r [0:`FC_NUM_CCOB-1];
	logic [2:0]              index_r;
	flash_ctrl_pkg::config_s cfg_r;
	logic                    complete_r;
	logic                    dbl_fault_r;
	logic                    sgl_fault_r;
	logic [1:0]              verify_err_r;
	logic                    accerr_r;
	logic                    key_locked_r;
	logic                    start_r;

	// ****************************************
	// Decode
	// ****************************************
	wire        loading    = (state_r == flash_ctrl_pkg::ST_HOLD) ||
				 (state_r == flash_ctrl_pkg::ST_LOAD);
	wire        rd_done    = loading && nvm_rd_rsp_i.valid;
	wire        rd_last    = rd_done && (rd_idx_r == `FC_LAST_RD);
	wire        bad_word   = nvm_rd_rsp_i.double_fault;
	wire        secure     = cfg_r.lock_register[`FC_LOCK_LSB +: 2] != `FC_LOCK_UNSECURED;
	wire [7:0]  op         = ccob_r[0][15:8];
	wire        key_on     = cfg_r.lock_register[`FC_KEY_EN_LSB +: 2] == `FC_KEY_EN_ENABLED;
	wire        idle       = state_r == flash_ctrl_pkg::ST_IDLE;
	wire        launch     = idle && complete_r && cmd_launch_i;
	wire        is_key     = op == `FC_OP_KEY_VERIFY;
	wire        key_usable = key_on && !key_locked_r;
	wire        accept     = cmd_allowed(op, special_single_chip_i, secure) &&
				 (!is_key || key_usable);
	wire        key_match  = (ccob_r[1] == keys_r[0]) && (ccob_r[2] == keys_r[1]) &&
				 (ccob_r[3] == keys_r[2]) && (ccob_r[4] == keys_r[3]) &&
				 key_ok(keys_r[0]) && key_ok(keys_r[1]) &&
				 key_ok(keys_r[2]) && key_ok(keys_r[3]);
	wire        in_key     = state_r == flash_ctrl_pkg::ST_KEY;
	wire        eng_end    = (state_r == flash_ctrl_pkg::ST_ENGINE) && engine_done_i;
	wire        eva_clean  = eng_end && (op == `FC_OP_ERASE_VERIFY_ALL) &&
				 special_single_chip_i && engine_erased_i;
	// Writes only land once the sequence is over and no command runs
	wire        ccob_we    = ccob_wr_i && idle && complete_r;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			flash_ctrl_pkg::ST_HOLD:   if (rd_done) begin
				state_nxt = flash_ctrl_pkg::ST_LOAD;
			end
			flash_ctrl_pkg::ST_LOAD:   if (rd_last) begin
				state_nxt = flash_ctrl_pkg::ST_IDLE;
			end
			flash_ctrl_pkg::ST_IDLE:   if (launch && accept) begin
				state_nxt = is_key ? flash_ctrl_pkg::ST_KEY : flash_ctrl_pkg::ST_ENGINE;
			end
			flash_ctrl_pkg::ST_ENGINE: if (engine_done_i) begin
				state_nxt = flash_ctrl_pkg::ST_IDLE;
			end
			flash_ctrl_pkg::ST_KEY:    state_nxt = flash_ctrl_pkg::ST_IDLE;
			default:                   state_nxt = flash_ctrl_pkg::ST_HOLD;
		endcase
	end

	// Sync reset also drops any running command; the array word is not recovered
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r  <= flash_ctrl_pkg::ST_HOLD;
			rd_idx_r <= 3'h0;
			start_r  <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			start_r  <= idle && launch && accept && !is_key;
			if (rd_done) begin
				rd_idx_r <= 3'(rd_idx_r + 3'h1);
			end
		end
	end

	// ****************************************
	// Reset-sequence load
	// ****************************************
	// Lock register is written only here, so a reprogrammed byte waits for reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			load_err_r <= 1'b0;
			cfg_r      <= '0;
			for (int i = 0; i < `FC_NUM_KEYS; i++) begin
				keys_r[i] <= `FC_KEY_ONES;
			end
		end else if (rd_done && !load_err_r && !bad_word) begin
			case (rd_idx_r)
				3'h0: cfg_r.param <= nvm_rd_rsp_i.data;
				3'h1: keys_r[0] <= nvm_rd_rsp_i.data;
				3'h2: keys_r[1] <= nvm_rd_rsp_i.data;
				3'h3: keys_r[2] <= nvm_rd_rsp_i.data;
				3'h4: keys_r[3] <= nvm_rd_rsp_i.data;
				3'h5: begin
					cfg_r.program_array_protection <= nvm_rd_rsp_i.data[15:8];
					cfg_r.data_array_protection    <= nvm_rd_rsp_i.data[7:0];
				end
				default: begin
					cfg_r.option_register <= nvm_rd_rsp_i.data[15:8];
					cfg_r.lock_register   <= nvm_rd_rsp_i.data[7:0];
				end
			endcase
		end else if (rd_done) begin
			// Any load error: fully protected and secured
			load_err_r                     <= 1'b1;
			cfg_r.param                    <= `FC_DFLT_PARAM;
			cfg_r.program_array_protection <= `FC_DFLT_PROG_PROT;
			cfg_r.data_array_protection    <= `FC_DFLT_DATA_PROT;
			cfg_r.option_register          <= `FC_DFLT_OPTION;
			cfg_r.lock_register            <= `FC_DFLT_LOCK;
		end else if ((in_key && key_match) || eva_clean) begin
			// Only the live state bits move; stored byte, keys, protection stay
			cfg_r.lock_register[`FC_LOCK_LSB +: 2] <= `FC_LOCK_UNSECURED;
		end
	end

	// ****************************************
	// Command object
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			index_r <= 3'h0;
			for (int i = 0; i < `FC_NUM_CCOB; i++) begin
				ccob_r[i] <= 16'h0000;
			end
		end else if (ccob_we && ccob_sel_index_i) begin
			index_r <= ccob_wdata_i[2:0];
		end else if (ccob_we && (index_r < 3'(`FC_NUM_CCOB))) begin
			ccob_r[index_r] <= ccob_wdata_i;
		end
	end

	// ****************************************
	// Flags
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			complete_r   <= 1'b0;
			verify_err_r <= 2'h0;
			accerr_r     <= 1'b0;
			key_locked_r <= 1'b0;
		end else begin
			if (rd_last || eng_end || in_key) begin
				complete_r <= 1'b1;
			end else if (launch && accept) begin
				complete_r <= 1'b0;
			end
			if (rd_done && bad_word) begin
				verify_err_r <= 2'h3;
			end else if (eng_end) begin
				verify_err_r <= engine_status_i;
			end else if (launch) begin
				verify_err_r <= 2'h0;
			end
			if (launch) begin
				accerr_r <= !accept;
			end else if (in_key && !key_match) begin
				accerr_r <= 1'b1;
			end
			if (in_key && !key_match) begin
				key_locked_r <= 1'b1;
			end
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dbl_fault_r <= 1'b0;
			sgl_fault_r <= 1'b0;
		end else begin
			dbl_fault_r <= ecc_double_i || (dbl_fault_r && !double_fault_clr_i);
			sgl_fault_r <= ecc_single_i || (sgl_fault_r && !single_fault_clr_i);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign nvm_rd_req_o             = loading;
	assign nvm_rd_addr_o            = load_addr(rd_idx_r);
	assign engine_start_o           = start_r;
	assign engine_op_o              = op;
	assign cpu_stall_o              = state_r == flash_ctrl_pkg::ST_HOLD;
	assign read_invalid_o           = in_key;
	assign stop_ack_o               = stop_req_i && complete_r && idle;
	assign cmd_irq_o                = complete_r && command_complete_irq_enable_i;
	assign err_irq_o                = (dbl_fault_r && double_fault_irq_enable_i) ||
					  (sgl_fault_r && single_fault_irq_enable_i);
	// Wait mode leaves the sequencer running; wake follows command irq
	assign wake_o                   = wait_mode_i && cmd_irq_o;
	assign command_complete_flag_o  = complete_r;
	assign double_fault_flag_o      = dbl_fault_r;
	assign single_fault_flag_o      = sgl_fault_r;
	assign verify_error_status_o    = verify_err_r;
	assign access_error_o           = accerr_r;
	assign protection_lock_state_o  = cfg_r.lock_register[`FC_LOCK_LSB +: 2];
	assign secured_o                = secure;
	assign command_index_register_o = index_r;
	assign config_o                 = cfg_r;

endmodule

// >>> verification/flash_ctrl_chk.sv
// Checker of interrupt, stop, security and reset-sequence behaviour
`timescale 1ns/10ps
module flash_ctrl_chk (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       wait_mode_i,
	input wire logic       command_complete_irq_enable_i,
	input wire logic       double_fault_irq_enable_i,
	input wire logic       single_fault_irq_enable_i,
	input wire logic       ecc_double_i,
	input wire logic       nvm_rd_req_o,
	input wire logic       engine_start_o,
	input wire logic       cpu_stall_o,
	input wire logic       read_invalid_o,
	input wire logic       stop_ack_o,
	input wire logic       wake_o,
	input wire logic       command_complete_flag_o,
	input wire logic       double_fault_flag_o,
	input wire logic       single_fault_flag_o,
	input wire logic       access_error_o,
	input wire logic       cmd_irq_o,
	input wire logic       err_irq_o,
	input wire logic [1:0] protection_lock_state_o,
	input wire logic       secured_o
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_cmd_irq_level: assert property (
		cmd_irq_o == (command_complete_flag_o && command_complete_irq_enable_i))
		else $error("cmd irq wrong");
	a_err_irq_level: assert property (
		err_irq_o == ((double_fault_flag_o && double_fault_irq_enable_i) ||
		(single_fault_flag_o && single_fault_irq_enable_i))) else $error("err irq wrong");
	a_wake_from_irq: assert property (
		wake_o == (wait_mode_i && cmd_irq_o)) else $error("wake wrong");
	a_stop_after_done: assert property (
		stop_ack_o |-> command_complete_flag_o) else $error("stop granted while busy");
	a_load_flag_low: assert property (
		nvm_rd_req_o |-> !command_complete_flag_o) else $error("flag set during load");
	a_key_read_invalid: assert property (
		read_invalid_o |=> command_complete_flag_o && !read_invalid_o)
		else $error("key check length");
	a_fault_sets_flag: assert property (
		ecc_double_i |=> double_fault_flag_o) else $error("double fault flag not set");
	a_reset_aborts_cmd: assert property (
		$rose(rst_n_i) |-> !command_complete_flag_o && cpu_stall_o)
		else $error("reset no abort");
	a_lock_secured: assert property (
		secured_o == (protection_lock_state_o != 2'h2)) else $error("secured mismatch");
	a_start_clears_flag: assert property (
		engine_start_o |-> !command_complete_flag_o) else $error("start with flag set");
	c_access_error: cover property ($rose(access_error_o));
	c_unlocked: cover property ($fell(secured_o));
	c_err_irq: cover property ($rose(err_irq_o));
	c_stop_ack: cover property ($rose(stop_ack_o));
endmodule

bind flash_irq_security_reset_ctrl flash_ctrl_chk u_chk (.clk_i, .rst_n_i, .wait_mode_i,
	.command_complete_irq_enable_i, .double_fault_irq_enable_i, .single_fault_irq_enable_i,
	.ecc_double_i, .nvm_rd_req_o, .engine_start_o, .cpu_stall_o, .read_invalid_o, .stop_ack_o,
	.wake_o, .command_complete_flag_o, .double_fault_flag_o, .single_fault_flag_o,
	.access_error_o, .cmd_irq_o, .err_irq_o, .protection_lock_state_o, .secured_o);

// >>> verification/nvm_model.sv
// Behavioural nonvolatile array answering the reset-sequence reads
`timescale 1ns/10ps
module nvm_model (
	input  wire logic                   clk_i,
	input  wire logic                   req_i,
	input  wire logic [17:0]            addr_i,
	input  wire logic [7:0]             lock_i,
	input  wire logic [15:0]            key0_i,
	input  wire logic                   dfault_i,
	input  wire logic                   slow_i,
	output flash_ctrl_pkg::nvm_rd_rsp_s rsp_o
);
	// ****************************************
	// Array contents and answer timing
	// ****************************************
	logic [15:0] word;
	logic        gap_r = '0;
	initial rsp_o = '0;
	always_comb begin
		case (addr_i)
			18'h3FF10: word = 16'h1234;
			18'h3FF00: word = key0_i;
			18'h3FF02: word = 16'h2222;
			18'h3FF04: word = 16'h3333;
			18'h3FF06: word = 16'h4444;
			18'h3FF0C: word = 16'hA55A;
			default:   word = {8'hC3, lock_i};
		endcase
	end
	// Idle data toggles so a stale word never reads as fresh
	always @(posedge clk_i) begin
		gap_r <= slow_i ? ~gap_r : 1'h0;
		if (req_i && !rsp_o.valid && !gap_r)
			rsp_o <= {1'h1, word, 1'h0, dfault_i && addr_i == 18'h3FF00};
		else
			rsp_o <= {1'h0, ~rsp_o.data, 2'h0};
	end
endmodule

// >>> verification/flash_irq_security_reset_ctrl_tb.sv
// Self-checking bench of the flash interrupt, security and reset control
`timescale 1ns/10ps
module flash_irq_security_reset_ctrl_tb;
	// ****************************************
	// Stimulus, model and design
	// ****************************************
	logic clk_i = '0, rst_n_i = '0, ssc = '0, wait_m = '0, stop_q = '0, cie = '0, die = '0;
	logic sie = '0, dclr = '0, sclr = '0, eccs = '0, eccd = '0, wr = '0, sel = '0, launch = '0;
	logic done = '0, erased = '0, df = '0, slow = 1'h1, dm = '0, sm = '0;
	logic [15:0] wdata = '0, key0 = '0;
	logic [1:0]  status = '0;
	logic [7:0]  lock = '0;
	logic [31:0] lfsr = 93379;
	logic        req, start, stall, rinv, sack, wake, flag, dff, sff, acc, cirq, eirq, locked;
	logic [17:0] addr;
	logic [7:0]  op_o;
	logic [1:0]  ves, pls;
	logic [2:0]  idx;
	int          mismatches = 0, checked = 0, cyc = 0;
	flash_ctrl_pkg::nvm_rd_rsp_s rsp;
	flash_ctrl_pkg::config_s     cfg;
	always #25 clk_i = ~clk_i;
	nvm_model u_nvm (.clk_i(clk_i), .req_i(req), .addr_i(addr), .lock_i(lock), .key0_i(key0),
		.dfault_i(df), .slow_i(slow), .rsp_o(rsp));
	flash_irq_security_reset_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.special_single_chip_i(ssc),
		.wait_mode_i(wait_m), .stop_req_i(stop_q), .command_complete_irq_enable_i(cie),
		.double_fault_irq_enable_i(die), .single_fault_irq_enable_i(sie), .double_fault_clr_i(dclr),
		.single_fault_clr_i(sclr), .ecc_single_i(eccs), .ecc_double_i(eccd), .ccob_wr_i(wr),
		.ccob_sel_index_i(sel), .ccob_wdata_i(wdata), .cmd_launch_i(launch), .engine_done_i(done),
		.engine_status_i(status), .engine_erased_i(erased), .nvm_rd_rsp_i(rsp), .nvm_rd_req_o(req),
		.nvm_rd_addr_o(addr), .engine_start_o(start), .engine_op_o(op_o), .cpu_stall_o(stall),
		.read_invalid_o(rinv), .stop_ack_o(sack), .wake_o(wake), .command_complete_flag_o(flag),
		.double_fault_flag_o(dff), .single_fault_flag_o(sff), .verify_error_status_o(ves),
		.access_error_o(acc), .cmd_irq_o(cirq), .err_irq_o(eirq), .protection_lock_state_o(pls),
		.secured_o(locked), .command_index_register_o(idx), .config_o(cfg));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] nxt(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic irq(logic f, logic e);
		return f & e;
	endfunction
	task summarize;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task tick;
		@(posedge clk_i);
		#5;
	endtask
	task chk(logic [63:0] got, logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// A completion that never comes counts as a mismatch
	task wait_flag;
		for (int n = 0; n < 60 && flag !== 1'h1; n++)
			tick();
		chk(flag, 1'h1);
	endtask
	// Index write during the load must be ignored
	task do_reset(logic sp, logic [7:0] lk, logic [15:0] k0, logic d);
		rst_n_i = '0;
		{ssc, lock, key0, df} = {sp, lk, k0, d};
		repeat (3) tick();
		rst_n_i = 1'h1;
		chk({flag, stall, req, addr}, {3'h3, 18'h3FF10});
		{wr, sel, wdata} = {2'h3, 16'h0005};
		tick();
		wr = '0;
		wait_flag();
		chk({req, flag, idx}, 5'h08);
	endtask
	task cmd(logic [7:0] op, logic [63:0] k);
		wr = 1'h1;
		for (int i = 0; i < 5; i++) begin
			{sel, wdata} = {1'h1, 16'(i)};
			tick();
			{sel, wdata} = {1'h0, (i == 0) ? {op, 8'h00} : k[16*(4-i) +: 16]};
			tick();
		end
		{wr, launch} = 2'h1;
		tick();
		launch = '0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		do_reset('0, 8'h80, 16'h1111, '0);
		chk({cfg, locked}, {16'h1234, 8'hA5, 8'h5A, 8'hC3, 8'h80, 1'h1});
		repeat (40) begin
			lfsr = nxt(lfsr);
			{cie, die, sie, eccs, eccd, sclr, dclr, wait_m} = lfsr[7:0];
			tick();
			dm = eccd | (dm & ~dclr);
			sm = eccs | (sm & ~sclr);
			chk({dff, sff}, {dm, sm});
			chk({cirq, eirq}, {cie, irq(dm, die) | irq(sm, sie)});
			chk(wake, wait_m & cie);
		end
		{eccs, eccd, sclr, dclr, wait_m} = '0;
		cmd(8'h0C, {lfsr[15:1], 1'h0, 48'h2222_3333_4444});
		chk(rinv, 1'h1);
		wait_flag();
		chk({acc, pls, locked}, 4'h9);
		cmd(8'h0C, 64'h1111_2222_3333_4444);
		chk({flag, acc, pls}, 4'hC);
		cmd(8'h08, '0);
		chk({flag, acc}, 2'h3);
		// Stored byte reprogrammed: live state waits for the next reset
		lock = 8'h82;
		tick();
		chk({pls, locked}, 3'h1);
		do_reset('0, 8'h82, 16'h1111, '0);
		chk({pls, locked}, 3'h4);
		do_reset('0, 8'h80, 16'h1111, '0);
		cmd(8'h0C, 64'h1111_2222_3333_4444);
		wait_flag();
		chk({acc, pls, locked, cfg[47:8]}, {4'h4, 40'h1234_A55A_C3});
		do_reset('0, 8'h80, 16'hFFFF, '0);
		cmd(8'h0C, 64'hFFFF_2222_3333_4444);
		wait_flag();
		chk({acc, pls}, 3'h4);
		do_reset(1'h1, 8'h80, 16'h1111, '0);
		cmd(8'h01, '0);
		stop_q = 1'h1;
		chk({start, op_o, sack}, {1'h1, 8'h01, 1'h0});
		tick();
		{status, erased, done} = {lfsr[9:8], 2'h3};
		tick();
		done = '0;
		wait_flag();
		chk({sack, ves, pls}, {1'h1, status, 2'h2});
		stop_q = '0;
		cmd(8'h08, '0);
		chk(flag, 1'h0);
		tick();
		done = 1'h1;
		tick();
		done = '0;
		wait_flag();
		// Left running on purpose so the reset below cuts it
		cmd(8'h01, '0);
		chk(flag, 1'h0);
		do_reset('0, 8'h80, 16'h1111, 1'h1);
		chk({cfg, ves, locked}, {40'h0000_0000_FF, 8'hFF, 2'h3, 1'h1});
		summarize();
	end
endmodule
